// ---- shared/fes_pkg.sv ----
// shared constants and types for the flash erase/program status host
package fes_pkg;
	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int T_CLK_NS = 8;
	localparam int T_WC_NS = 100;
	localparam int T_WP_NS = 50;
	localparam int T_ACC_NS = 100;
	localparam int T_RP_NS = 500;
	localparam int T_READY_IDLE_NS = 500;
	localparam int T_READY_ALG_US = 20;
	localparam int T_PROG_MAX_US = 300;
	localparam int WP_CYC = (T_WP_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int WC_CYC = (T_WC_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int ACC_CYC = (T_ACC_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int SYNC_CYC = 2;
	localparam int RP_CYC = (T_RP_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int READY_IDLE_CYC = (T_READY_IDLE_NS + T_CLK_NS - 1) / T_CLK_NS;
	localparam int READY_ALG_CYC = (T_READY_ALG_US * 1000 + T_CLK_NS - 1) / T_CLK_NS;
	localparam int PROG_MAX_CYC = (T_PROG_MAX_US * 1000 + T_CLK_NS - 1) / T_CLK_NS;
	localparam int CNT_W = 16;
	localparam int PH_W = 5;
	// ----------------------------------------------------------------
	// bus widths and status bit positions
	// ----------------------------------------------------------------
	localparam int AW = 20;
	localparam int DW = 8;
	localparam int POLL_BIT = 7;
	localparam int TOGGLE_BIT = 6;
	localparam int FAIL_BIT = 5;
	localparam int WINDOW_BIT = 3;
	localparam int SECT_TOG_BIT = 2;
	// ----------------------------------------------------------------
	// command cycle codes
	// ----------------------------------------------------------------
	localparam logic [AW-1:0] UNLOCK_A1 = 20'h00555;
	localparam logic [AW-1:0] UNLOCK_A2 = 20'h002aa;
	localparam logic [DW-1:0] UNLOCK_D1 = 8'haa;
	localparam logic [DW-1:0] UNLOCK_D2 = 8'h55;
	localparam logic [DW-1:0] FL_PROGRAM = 8'ha0;
	localparam logic [DW-1:0] FL_ERASE_SETUP = 8'h80;
	localparam logic [DW-1:0] FL_CHIP_ERASE = 8'h10;
	localparam logic [DW-1:0] FL_SECTOR_ERASE = 8'h30;
	localparam logic [DW-1:0] FL_SUSPEND = 8'hb0;
	localparam logic [DW-1:0] FL_RESUME = 8'h30;
	localparam logic [DW-1:0] FL_RESET = 8'hf0;
	localparam logic [2:0] LEN_ONE = 3'h1;
	localparam logic [2:0] LEN_PROG = 3'h4;
	localparam logic [2:0] LEN_ERASE = 3'h6;
	// ----------------------------------------------------------------
	// user orders and results
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		OP_READ, OP_POLL, OP_PROGRAM, OP_SECTOR_ERASE, OP_ADD_SECTOR,
		OP_CHIP_ERASE, OP_SUSPEND, OP_RESUME, OP_RESET, OP_HW_RESET
	} fes_op_e;
	typedef struct packed {
		logic busy;
		logic fail;
		logic erase_started;
		logic not_accepted;
		logic in_erase_sector;
		logic suspended;
	} fes_result_s;
	typedef struct packed {
		logic go;
		logic wr;
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
	} fes_bus_req_s;
endpackage

// ---- logic/fes_bus_cycle.sv ----
// one asynchronous read or write cycle on the flash pins
`timescale 1ns/10ps
module fes_bus_cycle import fes_pkg::*; (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire fes_bus_req_s i_req,
	output logic o_done,
	output logic [DW-1:0] o_rdata,
	input wire logic [DW-1:0] i_flash_data,
	output logic [AW-1:0] o_flash_addr,
	output logic [DW-1:0] o_flash_data,
	output logic o_flash_data_oe,
	output logic o_flash_select_n,
	output logic o_flash_output_en_n,
	output logic o_flash_write_en_n
);
	typedef enum logic [1:0] {PH_IDLE, PH_STROBE, PH_RECOV} fes_ph_e;
	typedef struct packed {
		fes_ph_e ph;
		logic [PH_W-1:0] cnt;
		logic wr;
		logic sel_n;
		logic oe_n;
		logic we_n;
		logic d_oe;
		logic done;
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
		logic [DW-1:0] rdata;
		logic [DW-1:0] d_s1;
		logic [DW-1:0] d_s2;
	} fes_bus_s;
	fes_bus_s b_q;
	fes_bus_s b_d;

	// ----------------------------------------------------------------
	// cycle sequencer
	// ----------------------------------------------------------------
	always_comb begin
		b_d = b_q;
		b_d.done = 1'b0;
		b_d.d_s1 = i_flash_data;
		b_d.d_s2 = b_q.d_s1;
		unique case (b_q.ph)
			PH_IDLE: begin
				if (i_req.go) begin
					b_d.ph = PH_STROBE;
					b_d.wr = i_req.wr;
					b_d.addr = i_req.addr;
					b_d.wdata = i_req.wdata;
					b_d.sel_n = 1'b0;
					b_d.oe_n = i_req.wr;
					b_d.we_n = !i_req.wr;
					b_d.d_oe = i_req.wr;
					b_d.cnt = i_req.wr ? PH_W'(WP_CYC - 1) : PH_W'(ACC_CYC + SYNC_CYC - 1);
				end
			end
			PH_STROBE: begin
				b_d.cnt = b_q.cnt - 1'b1;
				if (b_q.cnt == '0) begin
					b_d.ph = PH_RECOV;
					b_d.sel_n = 1'b1;
					b_d.oe_n = 1'b1;
					b_d.we_n = 1'b1;
					b_d.rdata = b_q.wr ? b_q.rdata : b_q.d_s2;
					b_d.cnt = PH_W'(WC_CYC - WP_CYC - 1);
				end
			end
			PH_RECOV: begin
				b_d.cnt = b_q.cnt - 1'b1;
				if (b_q.cnt == '0) begin
					b_d.ph = PH_IDLE;
					b_d.d_oe = 1'b0;
					b_d.done = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			b_q <= '{ph: PH_IDLE, sel_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
		end else begin
			b_q <= b_d;
		end
	end

	assign o_done = b_q.done;
	assign o_rdata = b_q.rdata;
	assign o_flash_addr = b_q.addr;
	assign o_flash_data = b_q.wdata;
	assign o_flash_data_oe = b_q.d_oe;
	assign o_flash_select_n = b_q.sel_n;
	assign o_flash_output_en_n = b_q.oe_n;
	assign o_flash_write_en_n = b_q.we_n;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	a_no_rw_clash: assert property (!(!o_flash_output_en_n && !o_flash_write_en_n))
		else $error("read and write strobes low together");
	a_we_pulse_width: assert property ($fell(o_flash_write_en_n) |-> !o_flash_write_en_n[*7])
		else $error("write strobe shorter than minimum");
endmodule

// ---- logic/fes_host.sv ----
// host controller issuing program/erase orders and decoding flash status
`timescale 1ns/10ps
// Functional notes
// - window check skippable only if spacing under 50us
// - confirm acceptance by toggle before reading window (code reads the window after the two toggle reads whatever tog shows)
// - read window bit before and after added sector
// - window high at second check: maybe not accepted
// - status reads use the valid target address
// - after failure write reset command
module fes_host import fes_pkg::*; #(
	parameter int PROG_MAX = PROG_MAX_CYC
) (
	input wire logic i_mclk,
	input wire logic i_reset_n,
	input wire logic i_cmd_valid,
	input wire fes_op_e i_cmd_op,
	input wire logic [AW-1:0] i_cmd_addr,
	input wire logic [DW-1:0] i_cmd_data,
	output logic o_cmd_ready,
	output logic o_done,
	output logic [DW-1:0] o_rdata,
	output fes_result_s o_result,
	input wire logic [DW-1:0] i_flash_data,
	output logic [AW-1:0] o_flash_addr,
	output logic [DW-1:0] o_flash_data,
	output logic o_flash_data_oe,
	output logic o_flash_select_n,
	output logic o_flash_output_en_n,
	output logic o_flash_write_en_n,
	output logic o_flash_reset_n,
	input wire logic i_ready_busy_out
);
	typedef enum logic [3:0] {
		ST_IDLE, ST_SEQ, ST_RD, ST_POLL_A, ST_POLL_B, ST_RECHK_A, ST_RECHK_B, ST_WIN,
		ST_PRE, ST_ADD_WR, ST_POST, ST_FAIL_RST, ST_HW_LOW, ST_HW_WAIT, ST_DONE
	} fes_st_e;
	typedef struct packed {
		fes_st_e st;
		fes_op_e op;
		logic issued;
		logic [2:0] idx;
		logic [AW-1:0] addr;
		logic [DW-1:0] data;
		logic [DW-1:0] first;
		logic [CNT_W-1:0] cnt;
		logic rb_s1;
		logic rb_s2;
		logic done;
		logic [DW-1:0] rdata;
		fes_result_s res;
	} fes_host_s;
	fes_host_s s_q;
	fes_host_s s_d;
	fes_bus_req_s req;
	logic bus_done;
	logic [DW-1:0] bus_rdata;
	logic tog;
	logic sec_tog;

	// ----------------------------------------------------------------
	// command cycle tables
	// ----------------------------------------------------------------
	function automatic logic [2:0] seq_len(input fes_op_e op);
		unique case (op)
			OP_PROGRAM: seq_len = LEN_PROG;
			OP_SECTOR_ERASE, OP_CHIP_ERASE: seq_len = LEN_ERASE;
			default: seq_len = LEN_ONE;
		endcase
	endfunction

	function automatic logic [AW+DW-1:0] seq_word(input fes_op_e op, input logic [2:0] idx,
			input logic [AW-1:0] a, input logic [DW-1:0] d);
		logic [DW-1:0] single;
		single = (op == OP_SUSPEND) ? FL_SUSPEND : (op == OP_RESUME) ? FL_RESUME : FL_RESET;
		if (seq_len(op) == LEN_ONE) begin
			seq_word = {a, single};
		end else begin
			unique case (idx)
				3'h0, 3'h3: seq_word = (op == OP_PROGRAM && idx == 3'h3) ? {a, d}
					: {UNLOCK_A1, UNLOCK_D1};
				3'h1, 3'h4: seq_word = {UNLOCK_A2, UNLOCK_D2};
				3'h2: seq_word = {UNLOCK_A1, (op == OP_PROGRAM) ? FL_PROGRAM : FL_ERASE_SETUP};
				default: seq_word = (op == OP_CHIP_ERASE) ? {UNLOCK_A1, FL_CHIP_ERASE}
					: {a, FL_SECTOR_ERASE};
			endcase
		end
	endfunction

	// ----------------------------------------------------------------
	// bus request and status decode
	// ----------------------------------------------------------------
	always_comb begin
		req.go = !s_q.issued && !(s_q.st inside {ST_IDLE, ST_HW_LOW, ST_HW_WAIT, ST_DONE});
		req.wr = s_q.st inside {ST_SEQ, ST_ADD_WR, ST_FAIL_RST};
		req.addr = s_q.addr;
		req.wdata = s_q.data;
		if (s_q.st == ST_SEQ) begin
			{req.addr, req.wdata} = seq_word(s_q.op, s_q.idx, s_q.addr, s_q.data);
		end else if (s_q.st == ST_ADD_WR) begin
			req.wdata = FL_SECTOR_ERASE;
		end else if (s_q.st == ST_FAIL_RST) begin
			req.wdata = FL_RESET;
		end
	end

	assign tog = bus_rdata[TOGGLE_BIT] ^ s_q.first[TOGGLE_BIT];
	assign sec_tog = bus_rdata[SECT_TOG_BIT] ^ s_q.first[SECT_TOG_BIT];

	// ----------------------------------------------------------------
	// order sequencer
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.done = 1'b0;
		s_d.rb_s1 = i_ready_busy_out;
		s_d.rb_s2 = s_q.rb_s1;
		if (req.go) begin
			s_d.issued = 1'b1;
		end
		if (bus_done) begin
			s_d.issued = 1'b0;
		end
		if (s_q.cnt != '0) begin
			s_d.cnt = s_q.cnt - 1'b1;
		end
		unique case (s_q.st)
			ST_IDLE: begin
				if (i_cmd_valid) begin
					s_d.op = i_cmd_op;
					s_d.addr = i_cmd_addr;
					s_d.data = i_cmd_data;
					s_d.idx = '0;
					s_d.res = '0;
					s_d.cnt = CNT_W'(PROG_MAX);
					unique case (i_cmd_op)
						OP_READ: s_d.st = ST_RD;
						OP_POLL: s_d.st = ST_POLL_A;
						OP_ADD_SECTOR: s_d.st = ST_PRE;
						OP_HW_RESET: begin
							s_d.st = ST_HW_LOW;
							s_d.cnt = CNT_W'(RP_CYC - 1);
						end
						default: s_d.st = ST_SEQ;
					endcase
				end
			end
			ST_SEQ: begin
				if (bus_done) begin
					s_d.idx = s_q.idx + 1'b1;
					if (s_q.idx == seq_len(s_q.op) - 1'b1) begin
						s_d.st = (s_q.op inside {OP_PROGRAM, OP_SECTOR_ERASE}) ? ST_POLL_A : ST_DONE;
					end
				end
			end
			ST_RD: begin
				if (bus_done) begin
					s_d.rdata = bus_rdata;
					s_d.st = ST_DONE;
				end
			end
			ST_POLL_A, ST_RECHK_A: begin
				if (bus_done) begin
					s_d.first = bus_rdata;
					s_d.st = (s_q.st == ST_POLL_A) ? ST_POLL_B : ST_RECHK_B;
				end
			end
			ST_POLL_B: begin
				if (bus_done) begin
					s_d.rdata = bus_rdata;
					s_d.res.busy = tog;
					s_d.res.in_erase_sector = sec_tog;
					if (s_q.op == OP_SECTOR_ERASE) begin
						s_d.st = ST_WIN;
					end else if (!tog) begin
						s_d.res.suspended = sec_tog;
						s_d.st = ST_DONE;
					end else if (bus_rdata[FAIL_BIT]) begin
						s_d.st = ST_RECHK_A;
					end else if (s_q.op == OP_PROGRAM) begin
						s_d.res.fail = (s_q.cnt == '0);
						s_d.st = (s_q.cnt == '0) ? ST_FAIL_RST : ST_POLL_A;
					end else begin
						s_d.st = ST_DONE;
					end
				end
			end
			ST_RECHK_B: begin
				if (bus_done) begin
					s_d.rdata = bus_rdata;
					s_d.res.busy = 1'b0;
					s_d.res.fail = tog;
					s_d.st = tog ? ST_FAIL_RST : ST_DONE;
				end
			end
			ST_WIN: begin
				if (bus_done) begin
					s_d.res.erase_started = bus_rdata[WINDOW_BIT];
					s_d.st = ST_DONE;
				end
			end
			ST_PRE: begin
				if (bus_done) begin
					s_d.res.erase_started = bus_rdata[WINDOW_BIT];
					s_d.res.not_accepted = bus_rdata[WINDOW_BIT];
					s_d.st = bus_rdata[WINDOW_BIT] ? ST_DONE : ST_ADD_WR;
				end
			end
			ST_ADD_WR: begin
				if (bus_done) begin
					s_d.st = ST_POST;
				end
			end
			ST_POST: begin
				if (bus_done) begin
					s_d.res.erase_started = bus_rdata[WINDOW_BIT];
					s_d.res.not_accepted = bus_rdata[WINDOW_BIT];
					s_d.st = ST_DONE;
				end
			end
			ST_FAIL_RST: begin
				if (bus_done) begin
					s_d.st = ST_DONE;
				end
			end
			ST_HW_LOW: begin
				if (s_q.cnt == '0) begin
					s_d.st = ST_HW_WAIT;
					s_d.cnt = s_q.rb_s2 ? CNT_W'(READY_IDLE_CYC) : CNT_W'(READY_ALG_CYC);
				end
			end
			ST_HW_WAIT: begin
				if (s_q.cnt == '0) begin
					s_d.st = ST_DONE;
				end
			end
			ST_DONE: begin
				s_d.done = 1'b1;
				s_d.st = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			s_q <= '{st: ST_IDLE, op: OP_READ, rb_s1: 1'b1, rb_s2: 1'b1, default: '0};
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// pin engine and outputs
	// ----------------------------------------------------------------
	fes_bus_cycle u_bus (
		.i_mclk(i_mclk),
		.i_reset_n(i_reset_n),
		.i_req(req),
		.o_done(bus_done),
		.o_rdata(bus_rdata),
		.i_flash_data(i_flash_data),
		.o_flash_addr(o_flash_addr),
		.o_flash_data(o_flash_data),
		.o_flash_data_oe(o_flash_data_oe),
		.o_flash_select_n(o_flash_select_n),
		.o_flash_output_en_n(o_flash_output_en_n),
		.o_flash_write_en_n(o_flash_write_en_n)
	);

	assign o_cmd_ready = (s_q.st == ST_IDLE);
	assign o_done = s_q.done;
	assign o_rdata = s_q.rdata;
	assign o_result = s_q.res;
	assign o_flash_reset_n = (s_q.st != ST_HW_LOW);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_reset_n);
	a_poll_addr_valid: assert property (
		(!o_flash_output_en_n && s_q.st inside {ST_POLL_A, ST_POLL_B, ST_RECHK_A, ST_RECHK_B,
		ST_WIN, ST_PRE, ST_POST}) |-> o_flash_addr == s_q.addr)
		else $error("status read away from target address");
	a_fail_reset_cmd: assert property (
		(s_q.st == ST_RECHK_B && bus_done && tog) |=> (s_q.st == ST_FAIL_RST && req.go
		&& req.wr && req.wdata == FL_RESET))
		else $error("reset command not written after failure");
	a_add_post_check: assert property (
		(s_q.st == ST_ADD_WR && bus_done) |=> s_q.st == ST_POST ##[1:40] bus_done)
		else $error("no window read after added sector");
	a_not_accepted_flag: assert property (
		(s_q.st inside {ST_PRE, ST_POST} && bus_done && bus_rdata[WINDOW_BIT])
		|=> s_q.res.not_accepted ##1 o_done)
		else $error("late window bit not reported");
	a_win_after_poll: assert property (
		(s_q.st == ST_WIN && $past(s_q.st) != ST_WIN) |-> $past(s_q.st) == ST_POLL_B)
		else $error("window read before acceptance check");
	a_reset_recovery: assert property (
		$rose(o_flash_reset_n) |-> !o_cmd_ready[*8])
		else $error("order taken too soon after flash reset");
endmodule

// ---- dv/fes_flash_model.sv ----
// behavioural flash device answering host command writes and status reads
`timescale 1ns/10ps
module fes_flash_model import fes_pkg::*; #(
	parameter int WIN_READS = 5,
	parameter int PROG_READS = 4,
	parameter int ERASE_READS = 12,
	parameter int RB_HOLD_NS = 2000
) (
	input wire logic i_reset_n,
	input wire logic [AW-1:0] i_addr,
	input wire logic [DW-1:0] i_data,
	input wire logic i_select_n,
	input wire logic i_output_en_n,
	input wire logic i_write_en_n,
	input wire logic i_fail_mode,
	output logic [DW-1:0] o_data,
	output logic o_ready_busy
);
	typedef enum logic [2:0] {M_IDLE, M_PROG, M_WIN, M_RUN, M_SUSP} fes_mode_e;
	fes_mode_e mode = M_IDLE;
	logic [DW-1:0] mem = 8'h5a, pd = 8'h00, last = 8'h00, stat;
	logic [3:0] sect = 4'h0;
	logic t6 = 1'b0, t2 = 1'b0, arm = 1'b0, all_s = 1'b0, hold = 1'b0;
	logic fail, in_s, busy;
	int seq = 0;
	int cnt = 0;
	// ----------------------------------------------------------------
	// status byte
	// ----------------------------------------------------------------
	assign in_s = all_s || i_addr[AW-1:16] == sect;
	assign fail = i_fail_mode && cnt >= 2;
	assign busy = mode inside {M_PROG, M_WIN, M_RUN};
	assign o_ready_busy = !busy && !hold;
	always_comb begin
		case (mode)
			M_PROG: stat = {~pd[7], t6, fail, 5'h00};
			M_WIN, M_RUN: stat = {1'b0, t6, 2'b00, mode == M_RUN, in_s & t2, 2'b00};
			M_SUSP: stat = in_s ? {1'b1, t6, 3'b000, t2, 2'b00} : mem;
			default: stat = mem;
		endcase
	end
	assign o_data = (!i_select_n && !i_output_en_n) ? stat : ~last;
	// ----------------------------------------------------------------
	// read, write and reset events
	// ----------------------------------------------------------------
	always @(posedge i_output_en_n) begin
		if (i_reset_n) begin
			last = stat;
			cnt++;
			if (busy) t6 = !t6;
			if (in_s && mode != M_PROG && mode != M_IDLE) t2 = !t2;
			if (mode == M_PROG && cnt >= PROG_READS && !i_fail_mode) begin
				mem = pd;
				mode = M_IDLE;
			end
			if (mode == M_WIN && cnt >= WIN_READS) begin
				mode = M_RUN;
				cnt = 0;
			end
			if (mode == M_RUN && cnt >= ERASE_READS) mode = M_IDLE;
		end
	end
	always @(posedge i_write_en_n) begin
		if (mode == M_RUN) begin
			if (i_data == FL_SUSPEND) mode = M_SUSP;
		end else if (i_data == FL_RESET) begin
			mode = M_IDLE;
			seq = 0;
		end else if (mode == M_SUSP && i_data == FL_RESUME) begin
			mode = M_RUN;
		end else if (mode == M_WIN && i_data == FL_SECTOR_ERASE) begin
			cnt = 0;
		end else if (arm) begin
			pd = i_data;
			mode = M_PROG;
			cnt = 0;
			arm = 1'b0;
		end else if ((seq == 0 || seq == 3) && i_data == UNLOCK_D1) begin
			seq++;
		end else if ((seq == 1 || seq == 4) && i_data == UNLOCK_D2) begin
			seq++;
		end else if (seq == 2 && i_data == FL_PROGRAM) begin
			arm = 1'b1;
			seq = 0;
		end else if (seq == 2 && i_data == FL_ERASE_SETUP) begin
			seq = 3;
		end else if (seq == 5) begin
			all_s = i_data == FL_CHIP_ERASE;
			sect = i_addr[AW-1:16];
			mode = all_s ? M_RUN : M_WIN;
			cnt = 0;
			seq = 0;
		end else begin
			seq = 0;
		end
	end
	always @(negedge i_reset_n) begin
		if (busy) hold = 1'b1;
		mode = M_IDLE;
		arm = 1'b0;
		all_s = 1'b0;
		seq = 0;
	end
	always @(posedge hold) begin
		#(RB_HOLD_NS);
		hold = 1'b0;
	end
endmodule

// ---- dv/tb.sv ----
// testbench for the flash status host against a behavioural device
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
	n_tests++; \
	if ((g) !== (e)) begin \
		n_mismatch++; \
		$display("mismatch %s expected %h seen %h", nm, e, g); \
	end \
end
module tb import fes_pkg::*;;
	logic mclk = 1'b0;
	logic reset_n = 1'b0;
	logic cmd_valid = 1'b0;
	fes_op_e cmd_op = OP_READ;
	logic [AW-1:0] cmd_addr = 20'h00000;
	logic [DW-1:0] cmd_data = 8'h00;
	logic fail_mode = 1'b0;
	logic cmd_ready, done, f_oe, f_sel_n, f_oen_n, f_we_n, f_rst_n, rb;
	logic [DW-1:0] rdata, f_dout, dev_data;
	logic [AW-1:0] f_addr;
	fes_result_s res;
	wire [DW-1:0] flash_in = f_oe ? f_dout : dev_data;
	int n_mismatch = 0;
	int n_tests = 0;
	int cyc = 0;
	int rst_cyc = 0;
	always #(T_CLK_NS / 2) mclk = ~mclk;
	always @(posedge mclk) if (f_rst_n === 1'b0) rst_cyc++;
	fes_host #(.PROG_MAX(2000)) u_fes_host (.i_mclk(mclk), .i_reset_n(reset_n),
		.i_cmd_valid(cmd_valid), .i_cmd_op(cmd_op), .i_cmd_addr(cmd_addr),
		.i_cmd_data(cmd_data), .o_cmd_ready(cmd_ready), .o_done(done), .o_rdata(rdata),
		.o_result(res), .i_flash_data(flash_in), .o_flash_addr(f_addr),
		.o_flash_data(f_dout), .o_flash_data_oe(f_oe), .o_flash_select_n(f_sel_n),
		.o_flash_output_en_n(f_oen_n), .o_flash_write_en_n(f_we_n),
		.o_flash_reset_n(f_rst_n), .i_ready_busy_out(rb));
	fes_flash_model u_fes_flash_model (.i_reset_n(f_rst_n), .i_addr(f_addr),
		.i_data(flash_in), .i_select_n(f_sel_n), .i_output_en_n(f_oen_n),
		.i_write_en_n(f_we_n), .i_fail_mode(fail_mode), .o_data(dev_data),
		.o_ready_busy(rb));
	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic run_op(input fes_op_e op, input logic [AW-1:0] a, input logic [DW-1:0] d);
		cmd_valid <= 1'b1;
		cmd_op <= op;
		cmd_addr <= a;
		cmd_data <= d;
		rst_cyc = 0;
		cyc = 0;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		do begin
			@(posedge mclk);
			cyc++;
		end while (done !== 1'b1 && cyc < 6000);
		if (cyc >= 6000) begin
			n_mismatch++;
			$display("mismatch order_done expected 1 seen 0");
			stop_test();
		end
	endtask
	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_program();
		run_op(OP_PROGRAM, 20'h01234, 8'h3c);
		`CHK("prog_busy", 1'b0, res.busy)
		`CHK("prog_fail", 1'b0, res.fail)
		`CHK("prog_data", 8'h3c, rdata)
		fail_mode <= 1'b1;
		run_op(OP_PROGRAM, 20'h01234, 8'h81);
		`CHK("prog_fail_flag", 1'b1, res.fail)
		fail_mode <= 1'b0;
		run_op(OP_READ, 20'h01234, 8'h00);
		`CHK("read_after_fail", 8'h3c, rdata)
	endtask
	task automatic t_erase();
		int k;
		run_op(OP_SECTOR_ERASE, 20'h30000, 8'h00);
		`CHK("window_early", 1'b0, res.erase_started)
		run_op(OP_ADD_SECTOR, 20'h30000, 8'h00);
		`CHK("add_taken", 1'b0, res.not_accepted)
		repeat (2) begin
			run_op(OP_POLL, 20'h30000, 8'h00);
			`CHK("window_busy", 1'b1, res.busy)
		end
		run_op(OP_ADD_SECTOR, 20'h30000, 8'h00);
		`CHK("add_refused", 1'b1, res.not_accepted)
		run_op(OP_RESET, 20'h30000, 8'h00);
		run_op(OP_POLL, 20'h30000, 8'h00);
		`CHK("erase_busy", 1'b1, res.busy)
		`CHK("erase_sector", 1'b1, res.in_erase_sector)
		`CHK("erase_rb", 1'b0, rb)
		run_op(OP_SUSPEND, 20'h30000, 8'h00);
		run_op(OP_POLL, 20'h30000, 8'h00);
		`CHK("susp_flag", 1'b1, res.suspended)
		`CHK("susp_poll_bit", 1'b1, rdata[POLL_BIT])
		`CHK("susp_rb", 1'b1, rb)
		run_op(OP_POLL, 20'h50000, 8'h00);
		`CHK("susp_other", 1'b0, res.in_erase_sector)
		`CHK("susp_other_data", 8'h3c, rdata)
		run_op(OP_RESUME, 20'h30000, 8'h00);
		k = 0;
		do begin
			run_op(OP_POLL, 20'h30000, 8'h00);
			k++;
		end while (res.busy === 1'b1 && k < 8);
		`CHK("erase_end", 1'b0, res.busy)
		`CHK("erase_end_rb", 1'b1, rb)
	endtask
	task automatic t_reset();
		run_op(OP_CHIP_ERASE, 20'h00555, 8'h00);
		run_op(OP_POLL, 20'h00000, 8'h00);
		`CHK("chip_busy", 1'b1, res.busy)
		`CHK("chip_no_window", 1'b1, rdata[WINDOW_BIT])
		run_op(OP_HW_RESET, 20'h00000, 8'h00);
		`CHK("pulse_len", RP_CYC, rst_cyc)
		`CHK("alg_wait", 1'b1, cyc >= RP_CYC + READY_ALG_CYC)
		`CHK("ready_after_reset", 1'b1, cmd_ready)
		run_op(OP_HW_RESET, 20'h00000, 8'h00);
		`CHK("idle_wait", 1'b1, cyc <= RP_CYC + READY_IDLE_CYC + 12)
		run_op(OP_READ, 20'h01234, 8'h00);
		`CHK("read_after_reset", 8'h3c, rdata)
	endtask
	initial begin
		repeat (6) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		t_program();
		t_erase();
		t_reset();
		stop_test();
	end
endmodule
